// *** include/dtcm_defs.svh ***
`ifndef DTCM_DEFS_SVH
`define DTCM_DEFS_SVH
`define DTCM_NUM_DIAG    4
`define DTCM_AW          8
`define DTCM_CLK_NS      40
`define DTCM_TICK_NS     1000000
`define DTCM_TICK_MS     1
`define DTCM_PERIOD_MS   1000
`define DTCM_HOLDOFF_MS  5000
`define DTCM_HIGH_SIDE   4'h5
`define DTCM_SUB_CFG     2'h0
`define DTCM_SUB_SPN     2'h1
`define DTCM_SUB_DLY     2'h2
`define DTCM_SUB_DTC     2'h3
`define DTCM_ADDR_STATUS 8'h40
`define DTCM_ADDR_OC     8'h44
`define DTCM_CFG_EN      0
`define DTCM_CFG_DM11    1
`define DTCM_CFG_LAMP    2
`define DTCM_CFG_FMI     8
`define DTCM_EN_RST      1'b1
`define DTCM_LAMP_RST    2'h2
`define DTCM_FMI_RST     5'h01
`define DTCM_SPN_RST     19'h7f000
`define DTCM_DLY_RST     16'h0064
`define DTCM_OC_MAX      7'h7f
`define DTCM_BCAST       8'hff
`define DTCM_OKAY        2'h0
`define DTCM_SLVERR      2'h2
`endif

// *** include/dtcm_pkg.sv ***
`include "dtcm_defs.svh"
package dtcm_pkg;
  typedef enum logic [2:0] {
    D_IDLE = 3'b001,
    D_PEND = 3'b010,
    D_ACT  = 3'b100
  } dtcm_dstate_type;
  typedef enum logic [1:0] {
    RQ_DM1  = 2'h0,
    RQ_DM2  = 2'h1,
    RQ_DM3  = 2'h2,
    RQ_DM11 = 2'h3
  } dtcm_rkind_type;
  typedef enum logic [1:0] {
    TX_SINGLE = 2'h0,
    TX_BAM    = 2'h1,
    TX_TP     = 2'h2
  } dtcm_xport_type;
  typedef struct packed {
    logic           valid;
    dtcm_rkind_type kind;
    logic [7:0]     src;
  } dtcm_req_type;
  typedef struct packed {
    logic                              valid;
    logic                              dm2;
    dtcm_xport_type                    xport;
    logic [7:0]                        dest;
    logic [7:0]                        lamp;
    logic [2:0]                        cnt;
    logic [`DTCM_NUM_DIAG-1:0]         mask;
    logic [`DTCM_NUM_DIAG-1:0][31:0]   dtc;
  } dtcm_tx_type;
  typedef struct packed {
    dtcm_dstate_type fsm;
    logic            prev;
    logic            en;
    logic            dm11;
    logic [1:0]      lamp;
    logic [4:0]      fmi;
    logic [18:0]     spn;
    logic [15:0]     dly;
    logic [15:0]     tmr;
    logic [6:0]      oc;
  } dtcm_diag_type;
  typedef struct packed {
    dtcm_diag_type [`DTCM_NUM_DIAG-1:0] d;
    logic [`DTCM_NUM_DIAG-1:0]          s1;
    logic [`DTCM_NUM_DIAG-1:0]          s2;
    logic [15:0]                        tick_c;
    logic [15:0]                        per_c;
    logic [15:0]                        hold_c;
    logic                               hold_done;
    logic                               pend_bc;
    logic                               pend_rq1;
    logic                               pend_rq2;
    logic [7:0]                         rq1_dst;
    logic [7:0]                         rq2_dst;
    dtcm_tx_type                        tx;
    logic                               nv_wr;
    logic [`DTCM_NUM_DIAG*7-1:0]        nv_oc;
    logic                               awh;
    logic                               wh;
    logic                               awr;
    logic                               wr;
    logic                               bv;
    logic [1:0]                         br;
    logic                               arr;
    logic                               rv;
    logic [31:0]                        rd;
    logic [1:0]                         rr;
    logic [`DTCM_AW-1:0]                awa;
    logic [31:0]                        wd;
    logic [3:0]                         ws;
  } dtcm_state_type;
endpackage : dtcm_pkg

// *** logic/dtcm_top.sv ***
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`include "dtcm_defs.svh"
module dtcm_top #(
  parameter int TICK_CYCLES   = `DTCM_TICK_NS / `DTCM_CLK_NS,
  parameter int PERIOD_TICKS  = `DTCM_PERIOD_MS / `DTCM_TICK_MS,
  parameter int HOLDOFF_TICKS = `DTCM_HOLDOFF_MS / `DTCM_TICK_MS
) (
  // clock and reset
  input  wire logic                        i_core_clk,
  input  wire logic                        i_reset_n,
  // fault conditions, asynchronous
  input  wire logic [`DTCM_NUM_DIAG-1:0]   i_fault,
  // requests from other nodes
  input  wire dtcm_pkg::dtcm_req_type      i_req,
  // message towards the transport layer
  output dtcm_pkg::dtcm_tx_type            o_tx,
  input  wire logic                        i_tx_ready,
  // non-volatile count log
  input  wire logic                        i_nv_load,
  input  wire logic [`DTCM_NUM_DIAG*7-1:0] i_nv_oc,
  output logic                             o_nv_wr,
  output logic [`DTCM_NUM_DIAG*7-1:0]      o_nv_oc,
  // axi4-lite write
  input  wire logic                        i_awvalid,
  output logic                             o_awready,
  input  wire logic [`DTCM_AW-1:0]         i_awaddr,
  input  wire logic                        i_wvalid,
  output logic                             o_wready,
  input  wire logic [31:0]                 i_wdata,
  input  wire logic [3:0]                  i_wstrb,
  output logic                             o_bvalid,
  input  wire logic                        i_bready,
  output logic [1:0]                       o_bresp,
  // axi4-lite read
  input  wire logic                        i_arvalid,
  output logic                             o_arready,
  input  wire logic [`DTCM_AW-1:0]         i_araddr,
  output logic                             o_rvalid,
  input  wire logic                        i_rready,
  output logic [31:0]                      o_rdata,
  output logic [1:0]                       o_rresp
);
  localparam int N = `DTCM_NUM_DIAG;

  dtcm_pkg::dtcm_state_type st;
  dtcm_pkg::dtcm_state_type next_st;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [4:0] fmi_high(input logic [4:0] f);
    case (f)
      5'h01:   fmi_high = 5'h00;
      5'h04:   fmi_high = 5'h03;
      5'h05:   fmi_high = 5'h06;
      5'h11:   fmi_high = 5'h0f;
      5'h12:   fmi_high = 5'h10;
      5'h15:   fmi_high = 5'h14;
      default: fmi_high = f;
    endcase
  endfunction : fmi_high

  function automatic logic [31:0] dtc_word(input dtcm_pkg::dtcm_diag_type d, input logic hi);
    logic [4:0] f;
    f = hi ? fmi_high(d.fmi) : d.fmi;
    dtc_word = {1'b0, d.oc, d.spn[18:16], f, d.spn[15:0]};
  endfunction : dtc_word

  function automatic logic [2:0] popcnt(input logic [N-1:0] v);
    popcnt = 3'h0;
    for (int i = 0; i < N; i++) begin
      popcnt = popcnt + 3'(v[i]);
    end
  endfunction : popcnt

  function automatic logic [N-1:0] svec(input dtcm_pkg::dtcm_state_type s,
                                        input dtcm_pkg::dtcm_dstate_type w);
    for (int i = 0; i < N; i++) begin
      svec[i] = (s.d[i].fsm == w);
    end
  endfunction : svec

  function automatic logic [N*7-1:0] ocvec(input dtcm_pkg::dtcm_state_type s);
    for (int i = 0; i < N; i++) begin
      ocvec[7*i +: 7] = s.d[i].oc;
    end
  endfunction : ocvec

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] w,
                                        input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      merge[8*b +: 8] = s[b] ? w[8*b +: 8] : o[8*b +: 8];
    end
  endfunction : merge

  function automatic logic [31:0] cfg_word(input dtcm_pkg::dtcm_diag_type d);
    cfg_word = {19'h0, d.fmi, 4'h0, d.lamp, d.dm11, d.en};
  endfunction : cfg_word

  // area: 0 diagnostic, 1 status, 2 counts, 3 unmapped
  function automatic logic [1:0] area(input logic [`DTCM_AW-1:0] a);
    if (a[7:6] == 2'h0) begin
      area = 2'h0;
    end else if (a[7:2] == `DTCM_ADDR_STATUS >> 2) begin
      area = 2'h1;
    end else if (a[7:2] == `DTCM_ADDR_OC >> 2) begin
      area = 2'h2;
    end else begin
      area = 2'h3;
    end
  endfunction : area

  function automatic dtcm_pkg::dtcm_tx_type mk_tx(input dtcm_pkg::dtcm_state_type s,
                                                  input logic dm2, input logic [7:0] dst);
    dtcm_pkg::dtcm_tx_type t;
    logic [N-1:0]          m;
    t = '0;
    m = '0;
    for (int i = 0; i < N; i++) begin
      m[i]     = dm2 ? s.d[i].prev : (s.d[i].fsm == dtcm_pkg::D_ACT);
      t.dtc[i] = dtc_word(s.d[i], 1'((`DTCM_HIGH_SIDE >> i) & 4'h1));
      if (m[i] && !dm2) begin
        t.lamp = t.lamp | (8'h40 >> {s.d[i].lamp, 1'b0});
      end
    end
    t.valid = 1'b1;
    t.dm2   = dm2;
    t.dest  = dst;
    t.mask  = m;
    t.cnt   = popcnt(m);
    if (t.cnt > 3'h1) begin
      t.xport = (dst == `DTCM_BCAST) ? dtcm_pkg::TX_BAM : dtcm_pkg::TX_TP;
    end else begin
      t.xport = dtcm_pkg::TX_SINGLE;
    end
    return t;
  endfunction : mk_tx

  function automatic dtcm_pkg::dtcm_state_type rst_state();
    rst_state = '0;
    for (int i = 0; i < N; i++) begin
      rst_state.d[i].fsm  = dtcm_pkg::D_IDLE;
      rst_state.d[i].en   = `DTCM_EN_RST;
      rst_state.d[i].lamp = `DTCM_LAMP_RST;
      rst_state.d[i].fmi  = `DTCM_FMI_RST;
      rst_state.d[i].spn  = `DTCM_SPN_RST + 19'(i);
      rst_state.d[i].dly  = `DTCM_DLY_RST;
    end
  endfunction : rst_state

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic                 tick;
    logic                 fire;
    logic                 ev;
    logic                 any_en;
    logic                 dm3;
    logic                 dm11;
    logic                 f;
    logic [1:0]           ar;
    logic [1:0]           wa;
    logic [31:0]          w;
    logic [$clog2(N)-1:0] wi;
    logic [$clog2(N)-1:0] ri;
    tick   = 1'b0;
    fire   = 1'b0;
    ev     = 1'b0;
    any_en = 1'b0;
    dm3    = 1'b0;
    dm11   = 1'b0;
    f      = 1'b0;
    ar     = 2'h0;
    wa     = 2'h0;
    w      = 32'h0;
    wi     = st.awa[5:4];
    ri     = i_araddr[5:4];
    next_st = st;
    // only s2 is read by logic
    next_st.s1 = i_fault;
    next_st.s2 = st.s1;
    dm3  = i_req.valid && (i_req.kind == dtcm_pkg::RQ_DM3);
    dm11 = i_req.valid && (i_req.kind == dtcm_pkg::RQ_DM11);
    // millisecond time base
    tick = (st.tick_c == 16'(TICK_CYCLES - 1));
    next_st.tick_c = tick ? 16'h0 : st.tick_c + 16'h1;
    if (tick && !st.hold_done) begin
      if (st.hold_c == 16'(HOLDOFF_TICKS - 1)) begin
        next_st.hold_done = 1'b1;
      end else begin
        next_st.hold_c = st.hold_c + 16'h1;
      end
    end
    for (int i = 0; i < N; i++) begin
      any_en = any_en | st.d[i].en;
    end
    if (tick && st.hold_done) begin
      if (st.per_c == 16'(PERIOD_TICKS - 1)) begin
        next_st.per_c = 16'h0;
        fire = any_en;
      end else begin
        next_st.per_c = st.per_c + 16'h1;
      end
    end
    // ----------------------------------------
    // diagnostics
    // ----------------------------------------
    for (int i = 0; i < N; i++) begin
      f = st.s2[i] & st.d[i].en;
      if (dm3) begin
        next_st.d[i].prev = 1'b0;
        if (st.d[i].fsm != dtcm_pkg::D_ACT) begin
          next_st.d[i].oc = 7'h0;
        end
      end
      case (st.d[i].fsm)
        dtcm_pkg::D_IDLE: begin
          if (f) begin
            next_st.d[i].fsm = dtcm_pkg::D_PEND;
            next_st.d[i].tmr = st.d[i].dly;
          end
        end
        dtcm_pkg::D_PEND: begin
          if (!f) begin
            next_st.d[i].fsm = dtcm_pkg::D_IDLE;
          end else if (st.d[i].tmr == 16'h0) begin
            next_st.d[i].fsm = dtcm_pkg::D_ACT;
            if (st.d[i].oc != `DTCM_OC_MAX) begin
              next_st.d[i].oc = st.d[i].oc + 7'h1;
            end
            ev = 1'b1;
          end else if (tick) begin
            next_st.d[i].tmr = st.d[i].tmr - 16'h1;
          end
        end
        dtcm_pkg::D_ACT: begin
          if (!st.d[i].en) begin
            next_st.d[i].fsm = dtcm_pkg::D_IDLE;
            ev = 1'b1;
          end else if (dm11 || (!st.s2[i] && !st.d[i].dm11)) begin
            next_st.d[i].fsm  = dtcm_pkg::D_IDLE;
            next_st.d[i].prev = 1'b1;
            ev = 1'b1;
          end
        end
        default: begin
          next_st.d[i].fsm = dtcm_pkg::D_IDLE;
        end
      endcase
    end
    // ----------------------------------------
    // message scheduling
    // ----------------------------------------
    if (!st.tx.valid || i_tx_ready) begin
      next_st.tx.valid = 1'b0;
      if (st.pend_rq1) begin
        next_st.tx = mk_tx(st, 1'b0, st.rq1_dst);
        next_st.pend_rq1 = 1'b0;
      end else if (st.pend_rq2) begin
        next_st.tx = mk_tx(st, 1'b1, st.rq2_dst);
        next_st.pend_rq2 = 1'b0;
      end else if (st.pend_bc) begin
        next_st.tx = mk_tx(st, 1'b0, `DTCM_BCAST);
        next_st.pend_bc = 1'b0;
      end
    end
    // new events win over the clear of a pending flag
    if (ev || fire) begin
      next_st.pend_bc = 1'b1;
    end
    if (i_req.valid && (i_req.kind == dtcm_pkg::RQ_DM1)) begin
      next_st.pend_rq1 = 1'b1;
      next_st.rq1_dst  = i_req.src;
    end
    if (i_req.valid && (i_req.kind == dtcm_pkg::RQ_DM2)) begin
      next_st.pend_rq2 = 1'b1;
      next_st.rq2_dst  = i_req.src;
    end
    // ----------------------------------------
    // axi4-lite write
    // ----------------------------------------
    if (i_awvalid && st.awr) begin
      next_st.awh = 1'b1;
      next_st.awa = i_awaddr;
    end
    if (i_wvalid && st.wr) begin
      next_st.wh = 1'b1;
      next_st.wd = i_wdata;
      next_st.ws = i_wstrb;
    end
    if (st.bv && i_bready) begin
      next_st.bv = 1'b0;
    end
    if (st.awh && st.wh) begin
      next_st.awh = 1'b0;
      next_st.wh  = 1'b0;
      next_st.bv  = 1'b1;
      wa = area(st.awa);
      next_st.br = (wa == 2'h3) ? `DTCM_SLVERR : `DTCM_OKAY;
      if (wa == 2'h0) begin
        case (st.awa[3:2])
          `DTCM_SUB_CFG: begin
            w = merge(cfg_word(st.d[wi]), st.wd, st.ws);
            next_st.d[wi].en   = w[`DTCM_CFG_EN];
            next_st.d[wi].dm11 = w[`DTCM_CFG_DM11];
            next_st.d[wi].lamp = w[`DTCM_CFG_LAMP +: 2];
            next_st.d[wi].fmi  = w[`DTCM_CFG_FMI +: 5];
            if (w[`DTCM_CFG_FMI +: 5] != st.d[wi].fmi) begin
              next_st.d[wi].oc = 7'h0;
            end
          end
          `DTCM_SUB_SPN: begin
            w = merge({13'h0, st.d[wi].spn}, st.wd, st.ws);
            next_st.d[wi].spn = w[18:0];
            if (w[18:0] != st.d[wi].spn) begin
              next_st.d[wi].oc = 7'h0;
            end
          end
          `DTCM_SUB_DLY: begin
            w = merge({16'h0, st.d[wi].dly}, st.wd, st.ws);
            next_st.d[wi].dly = w[15:0];
          end
          default: begin
          end
        endcase
      end
    end
    next_st.awr = !next_st.awh && !next_st.bv;
    next_st.wr  = !next_st.wh && !next_st.bv;
    // ----------------------------------------
    // axi4-lite read
    // ----------------------------------------
    if (st.rv && i_rready) begin
      next_st.rv = 1'b0;
    end
    if (i_arvalid && st.arr) begin
      next_st.rv = 1'b1;
      ar = area(i_araddr);
      next_st.rr = (ar == 2'h3) ? `DTCM_SLVERR : `DTCM_OKAY;
      case (ar)
        2'h0: begin
          case (i_araddr[3:2])
            `DTCM_SUB_CFG: next_st.rd = cfg_word(st.d[ri]);
            `DTCM_SUB_SPN: next_st.rd = {13'h0, st.d[ri].spn};
            `DTCM_SUB_DLY: next_st.rd = {16'h0, st.d[ri].dly};
            default:       next_st.rd = dtc_word(st.d[ri], 1'((`DTCM_HIGH_SIDE >> ri) & 4'h1));
          endcase
        end
        2'h1: next_st.rd = {19'h0, st.hold_done, svec(st, dtcm_pkg::D_PEND),
                            st.d[3].prev, st.d[2].prev, st.d[1].prev, st.d[0].prev,
                            svec(st, dtcm_pkg::D_ACT)};
        2'h2: next_st.rd = {4'h0, ocvec(st)};
        default: next_st.rd = 32'h0;
      endcase
    end
    next_st.arr = !next_st.rv;
    // ----------------------------------------
    // count log
    // ----------------------------------------
    // the restore replaces every count and is not echoed back to storage
    if (i_nv_load) begin
      for (int i = 0; i < N; i++) begin
        next_st.d[i].oc = i_nv_oc[7*i +: 7];
      end
    end
    next_st.nv_wr = !i_nv_load && (ocvec(next_st) != ocvec(st));
    next_st.nv_oc = ocvec(next_st);
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      st <= rst_state();
    end else begin
      st <= next_st;
    end
  end

  assign o_tx      = st.tx;
  assign o_nv_wr   = st.nv_wr;
  assign o_nv_oc   = st.nv_oc;
  assign o_awready = st.awr;
  assign o_wready  = st.wr;
  assign o_bvalid  = st.bv;
  assign o_bresp   = st.br;
  assign o_arready = st.arr;
  assign o_rvalid  = st.rv;
  assign o_rdata   = st.rd;
  assign o_rresp   = st.rr;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [2:0] act_cnt;
  logic       a0;
  logic       dm11_seen;
  assign act_cnt   = popcnt(svec(st, dtcm_pkg::D_ACT));
  assign a0        = (st.d[0].fsm == dtcm_pkg::D_ACT);
  assign dm11_seen = i_req.valid && (i_req.kind == dtcm_pkg::RQ_DM11);

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_reset_n);

  AST_OC_SAT: assert property (
    $rose(st.d[1].fsm == dtcm_pkg::D_ACT) && $past(st.d[1].oc) == `DTCM_OC_MAX |-> st.d[1].oc == `DTCM_OC_MAX)
    else $error("count wrapped past maximum");
  AST_OC_INC: assert property (
    $rose(a0) && $past(st.d[0].oc) != `DTCM_OC_MAX && !$past(i_nv_load) && !$past(st.awh && st.wh)
    |-> st.d[0].oc == $past(st.d[0].oc) + 7'h1)
    else $error("count not incremented on activation");
  AST_DELAY: assert property (
    $rose(a0) |-> $past(st.d[0].fsm) == dtcm_pkg::D_PEND && $past(st.d[0].tmr) == 16'h0)
    else $error("activation before delay expiry");
  AST_ABANDON: assert property (
    st.d[0].fsm == dtcm_pkg::D_PEND && !st.s2[0] |=> st.d[0].fsm == dtcm_pkg::D_IDLE)
    else $error("pending fault not abandoned");
  AST_EN_GATE: assert property (
    !st.d[0].en |=> !a0)
    else $error("disabled diagnostic active");
  AST_DROP_EV: assert property (
    act_cnt < $past(act_cnt) |-> st.pend_bc)
    else $error("no dm1 after code dropped");
  AST_NEW_EV: assert property (
    act_cnt > $past(act_cnt) |-> st.pend_bc)
    else $error("no dm1 after activation");
  AST_BAM: assert property (
    o_tx.valid && o_tx.dest == `DTCM_BCAST && o_tx.cnt > 3'h1 |-> o_tx.xport == dtcm_pkg::TX_BAM)
    else $error("broadcast multi-code dm1 not bam");
  AST_TP: assert property (
    o_tx.valid && !o_tx.dm2 && o_tx.dest != `DTCM_BCAST && o_tx.cnt > 3'h1
    |-> o_tx.xport == dtcm_pkg::TX_TP)
    else $error("requested multi-code dm1 not tp");
  AST_DM2_REQ: assert property (
    $rose(o_tx.valid) && o_tx.dm2 |-> $past(st.pend_rq2))
    else $error("dm2 sent without request");
  AST_AUTO_CLR: assert property (
    a0 && st.d[0].en && !st.d[0].dm11 && !st.s2[0] |=> !a0 && st.d[0].prev)
    else $error("code not moved to previously active");
  AST_DM11_HOLD: assert property (
    a0 && st.d[0].en && st.d[0].dm11 && !dm11_seen |=> a0)
    else $error("dm11-only code cleared early");
  AST_HOLD: assert property (
    !st.hold_done |-> st.per_c == 16'h0 && !(o_tx.valid && $rose(o_tx.valid) && act_cnt == 3'h0
                                               && !$past(st.pend_rq1) && !$past(st.pend_rq2)
                                               && !$past(st.pend_bc)))
    else $error("periodic schedule ran during hold-off");
  AST_NO_FAULT: assert property (
    o_tx.valid && !o_tx.dm2 && o_tx.mask == '0 |-> o_tx.lamp == 8'h00 && o_tx.cnt == 3'h0)
    else $error("no-fault dm1 carries content");

  COV_BAM:  cover property (o_tx.valid && o_tx.xport == dtcm_pkg::TX_BAM);
  COV_TP:   cover property (o_tx.valid && o_tx.xport == dtcm_pkg::TX_TP);
  COV_DM11: cover property (a0 && st.d[0].dm11 && dm11_seen ##1 !a0);
  COV_DM2:  cover property (o_tx.valid && o_tx.dm2);
endmodule : dtcm_top

// *** testbench/dtcm_ecu_model.sv ***
module dtcm_ecu_model (
  // link to the diagnostic block
  input  wire logic                  i_core_clk,
  input  wire dtcm_pkg::dtcm_tx_type i_tx,
  input  wire logic                  i_slow,
  output logic                       o_ready,
  output dtcm_pkg::dtcm_tx_type      o_got,
  output logic                       o_hit
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ph = 1'b0;
  // slow mode takes a message only every other cycle, like a busy transport
  assign o_ready = !i_slow || ph;
  always @(posedge i_core_clk) begin
    ph <= !ph;
    o_hit <= i_tx.valid && o_ready;
    if (i_tx.valid && o_ready) begin
      o_got <= i_tx;
    end
  end
endmodule : dtcm_ecu_model

// *** testbench/j1939_diagnostic_dtc_manager_tb.sv ***
module j1939_diagnostic_dtc_manager_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                   clk = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   nvl = 1'b0;
  logic                   slow = 1'b0;
  logic [3:0]             fault = 4'h0;
  dtcm_pkg::dtcm_req_type req = '0;
  dtcm_pkg::dtcm_tx_type  tx;
  dtcm_pkg::dtcm_tx_type  got;
  logic                   rdy, hit, awr, wr, bv, arr, rv;
  logic                   awv = 1'b0, wv = 1'b0, bry = 1'b1, arv = 1'b0, rry = 1'b1;
  logic                   nvw;
  logic [27:0]            nvo;
  int                     nwr = 0;
  logic [1:0]             br, rr, r;
  logic [7:0]             awa = 8'h00, ara = 8'h00;
  logic [31:0]            wd = 32'h0, rd, v;
  int                     mismatches = 0, n_tests = 0;
  always #20 clk = ~clk;
  always @(posedge clk) if (nvw === 1'b1) nwr <= nwr + 1;
  dtcm_top #(.TICK_CYCLES(4), .PERIOD_TICKS(20), .HOLDOFF_TICKS(10)) uut (
    .i_core_clk(clk), .i_reset_n(rst_n), .i_fault(fault), .i_req(req), .o_tx(tx), .i_tx_ready(rdy),
    .i_nv_load(nvl), .i_nv_oc({7'h00, 7'h00, 7'h7f, 7'h00}), .o_nv_wr(nvw), .o_nv_oc(nvo),
    .i_awvalid(awv), .o_awready(awr), .i_awaddr(awa), .i_wvalid(wv), .o_wready(wr), .i_wdata(wd),
    .i_wstrb(4'hf), .o_bvalid(bv), .i_bready(bry), .o_bresp(br), .i_arvalid(arv), .o_arready(arr),
    .i_araddr(ara), .o_rvalid(rv), .i_rready(rry), .o_rdata(rd), .o_rresp(rr));
  dtcm_ecu_model ecu (.i_core_clk(clk), .i_tx(tx), .i_slow(slow), .o_ready(rdy), .o_got(got), .o_hit(hit));
  // ------------------------------
  // shared tasks
  // ------------------------------
  task results;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results
  task tmo;
    mismatches++;
    results;
  endtask : tmo
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task axw(input logic [7:0] a, input logic [31:0] d);
    int k;
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= a;
    wd <= d;
    for (k = 0; k < 99; k++) begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
      if (bv) break;
    end
    if (k == 99) tmo;
  endtask : axw
  task axr(input logic [7:0] a);
    int k;
    arv <= 1'b1;
    ara <= a;
    for (k = 0; k < 99; k++) begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    v = rd;
    r = rr;
    if (k == 99) tmo;
  endtask : axr
  // waits for a message with the given contents, a timeout if none comes
  task msg(input logic [3:0] m, input logic [7:0] dst, input logic d2);
    int k;
    for (k = 0; k < 3000; k++) begin
      @(posedge clk);
      if (hit === 1'b1 && got.mask === m && got.dest === dst && got.dm2 === d2) break;
    end
    if (k == 3000) tmo;
  endtask : msg
  task rq(input dtcm_pkg::dtcm_rkind_type kd, input logic [7:0] s);
    req <= '{1'b1, kd, s};
    @(posedge clk);
    req.valid <= 1'b0;
  endtask : rq
  // ------------------------------
  // scenarios
  // ------------------------------
  task t_regs;
    axr(8'h00);
    chk(v, 32'h109);
    axr(8'h14);
    chk(v, 32'h7f001);
    axr(8'hfc);
    chk(32'(r), 32'h2);
    axw(8'h08, 32'h2);
    axw(8'h18, 32'h2);
    $display("regs done");
  endtask : t_regs
  task t_act;
    fault <= 4'h3;
    msg(4'h3, 8'hff, 1'b0);
    chk(got.dtc[0], {1'b0, 7'h01, 3'h7, 5'h00, 16'hf000});
    chk(got.dtc[1], {1'b0, 7'h7f, 3'h7, 5'h01, 16'hf001});
    chk(32'(got.lamp), 32'h04);
    chk(32'(got.xport), 32'(dtcm_pkg::TX_BAM));
    chk(32'(nvo), 32'h3f81);
    chk(nwr, 32'h1);
    slow <= 1'b1;
    rq(dtcm_pkg::RQ_DM1, 8'h21);
    msg(4'h3, 8'h21, 1'b0);
    chk(32'(got.xport), 32'(dtcm_pkg::TX_TP));
    $display("activation done");
  endtask : t_act
  task t_drop;
    fault <= 4'h0;
    msg(4'h0, 8'hff, 1'b0);
    chk(32'(got.cnt), 32'h0);
    chk(32'(got.lamp), 32'h0);
    rq(dtcm_pkg::RQ_DM2, 8'h33);
    msg(4'h3, 8'h33, 1'b1);
    rq(dtcm_pkg::RQ_DM3, 8'h33);
    // pulse shorter than the 2 ms delay of diagnostic 0
    fault <= 4'h1;
    repeat (3) @(posedge clk);
    fault <= 4'h0;
    repeat (6) @(posedge clk);
    axr(8'h40);
    chk(v, 32'h1000);
    axr(8'h44);
    chk(v, 32'h0);
    $display("drop done");
  endtask : t_drop
  task t_dm11;
    axw(8'h00, 32'h10b);
    fault <= 4'h1;
    msg(4'h1, 8'hff, 1'b0);
    fault <= 4'h0;
    repeat (20) @(posedge clk);
    msg(4'h1, 8'hff, 1'b0);
    rq(dtcm_pkg::RQ_DM11, 8'h44);
    msg(4'h0, 8'hff, 1'b0);
    axr(8'h44);
    chk(v, 32'h1);
    axw(8'h00, 32'h108);
    fault <= 4'h1;
    repeat (16) @(posedge clk);
    axr(8'h40);
    chk(v, 32'h1010);
    fault <= 4'h0;
    slow <= 1'b0;
    $display("dm11 done");
  endtask : t_dm11
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    nvl <= 1'b1;
    @(posedge clk);
    nvl <= 1'b0;
    t_regs;
    t_act;
    t_drop;
    t_dm11;
    results;
  end
endmodule : j1939_diagnostic_dtc_manager_tb
